// *** inc/mxslc_pkg.sv ***
// mxslc_pkg: constants and carrier types for the mux system/line control block
// assumes a 32-bit classic wishbone slave port with byte addresses
package mxslc_pkg;

  localparam int NUM_LINES  = 16;
  localparam int NUM_GROUPS = 4;
  localparam int SILO_DEPTH = 64;
  localparam int REG_W      = 16;

  // register byte offsets
  localparam logic [7:0] OFS_SYSCTL = 8'h00;
  localparam logic [7:0] OFS_LINECTL = 8'h04;
  localparam logic [7:0] OFS_SELECT = 8'h08;
  localparam logic [7:0] OFS_SILO = 8'h0C;
  localparam logic [7:0] OFS_RXCHAR = 8'h10;
  localparam logic [7:0] OFS_LSTATE = 8'h14;

  // system_control fields
  localparam int SC_GO    = 0;
  localparam int SC_EXT   = 4;
  localparam int SC_RXIE  = 6;
  localparam int SC_RXREQ = 7;
  localparam int SC_SVC   = 8;
  localparam int SC_MWE   = 9;
  localparam int SC_OVF   = 10;
  localparam int SC_MCLR  = 11;
  localparam int SC_OVFIE = 12;
  localparam int SC_STIE  = 13;
  localparam int SC_STAT  = 15;
  localparam logic [15:0] SC_RESET     = 16'h0000;
  localparam logic [15:0] SC_WR_MASK   = 16'h367F;
  localparam logic [15:0] SC_MAINT_WR  = 16'h8080;
  localparam logic [15:0] SC_MCLR_KEEP = 16'h0130;

  // line_control fields
  localparam int LC_EXT    = 4;
  localparam int LC_M09    = 9;
  localparam int LC_SYNC   = 10;
  localparam int LC_M11    = 11;
  localparam int LC_M12    = 12;
  localparam int LC_RXEN   = 13;
  localparam int LC_M14    = 14;
  localparam int LC_STROBE = 15;

  // line state fields
  localparam int LS_ACTIVE = 0;
  localparam int LS_RESYNC = 1;

  localparam logic [15:0] SEL_RESET  = 16'h0000;
  localparam logic [15:0] RXC_RESET  = 16'h0000;
  localparam logic [15:0] LINE_RESET = 16'h0000;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } mxslc_wb_req_t;

  // receive event, laid out as the rx interrupt character register
  typedef struct packed {
    logic [3:0] code;
    logic [3:0] line;
    logic [7:0] rxChar;
  } mxslc_rx_evt_t;

  typedef struct packed {
    logic maint14;
    logic maint12;
    logic maint11;
    logic syncB;
    logic maint09;
  } mxslc_grp_ctl_t;

  localparam mxslc_grp_ctl_t GRP_RESET = '0;

endpackage

// *** rtl/mxslc_status_silo.sv ***
// mxslc_status_silo: first-in first-out store for transmit status entries
// assumes push and pop come from logic on the same clock
`timescale 1ns/100ps
`default_nettype none
module mxslc_status_silo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 64
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  // control
  input  wire logic                     flush,
  input  wire logic                     push,
  input  wire logic [WIDTH-1:0]         pushData,
  input  wire logic                     pop,
  // state
  output logic      [WIDTH-1:0]         head,
  output logic      [$clog2(DEPTH):0]   count,
  output logic                          full,
  output logic                          empty
);
  import mxslc_pkg::*;

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  wire              doPop  = pop & ~empty;
  wire              doPush = push & (~full | doPop);

  assign full  = (count == (AW+1)'(DEPTH));
  assign empty = (count == '0);
  assign head  = mem[rdPtr];

  always_ff @(posedge clk) begin
    if (doPush && !flush) begin
      mem[wrPtr] <= pushData;
    end
  end

  // oldest entry leaves on pop, next one falls to the head
  always_ff @(posedge clk) begin
    if (!reset_n || flush) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      wrPtr <= wrPtr + AW'(doPush);
      rdPtr <= rdPtr + AW'(doPop);
      count <= count + (AW+1)'(doPush) - (AW+1)'(doPop);
    end
  end

endmodule
`default_nettype wire

// *** rtl/mxslc_top.sv ***
// mxslc_top: system control and line control registers of a sync comms mux
// assumes a classic wishbone master and a sequencing engine on the same clock
//
// Function
// - strobe copies receiver enable into storage of the selected line
// - strobe copies sync select and maintenance bits into the group storage
// - line control bits 4-5 read extended address of selected secondary register
// - sync select zero picks first sync, one second; reset clears it
// - enabled receiver hunts for sync; finding it sets receiver active
// - engine go bit gates data handling; reset clears it
// - extended address bits read back as written; reset clears them
// - receive events set request flag; interrupt only with enable set
// - receive request flag writable only with maintenance write enable
// - service complete clears receive request and resumes the engine
// - full status silo sets overflow; interrupt only with its enable
// - master clear clears listed control bits and silos, then self-clears
// - status push sets status flag, silo read clears it, enable gates irq
// - status flag writable only with maintenance write enable
// - status silo is a 64-entry fifo read destructively
// - selector bits 0-3 choose the line for strobed access
`timescale 1ns/100ps
`default_nettype none
module mxslc_top #(
  parameter int NUM_LINES  = mxslc_pkg::NUM_LINES,
  parameter int SILO_DEPTH = mxslc_pkg::SILO_DEPTH
) (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          reset_n,
  // wishbone slave
  input  wire mxslc_pkg::mxslc_wb_req_t      wbReq,
  output logic                               wbAck,
  output logic      [31:0]                   wbDatOut,
  // sequencing engine events
  input  wire logic                          rxEvtValid,
  input  wire mxslc_pkg::mxslc_rx_evt_t      rxEvt,
  input  wire logic                          statusPush,
  input  wire logic [15:0]                   statusEntry,
  input  wire logic                          syncFound,
  input  wire logic [3:0]                    syncLine,
  input  wire logic [1:0]                    secAddrHi,
  // engine control
  output logic                               engineGo,
  output logic      [1:0]                    extAddr,
  output logic                               serviceComplete,
  output logic                               masterClear,
  output logic      [15:0]                   lineSelect,
  output logic      [NUM_LINES-1:0]          lineRxEnable,
  output logic      [NUM_LINES-1:0]          lineHunt,
  output mxslc_pkg::mxslc_grp_ctl_t [3:0]    groupCtl,
  // interrupt requests to the system bus
  output logic                               rxIrqReq,
  output logic                               statIrqReq
);
  import mxslc_pkg::*;

  logic [15:0]           sysCtl;
  logic [15:0]           next_sysCtl;
  logic [15:0]           rxCharReg;
  logic [NUM_LINES-1:0]  rxActive;
  logic [NUM_LINES-1:0]  next_rxActive;
  logic [NUM_LINES-1:0]  next_rxEnable;
  logic [15:0]           siloHead;
  logic [$clog2(SILO_DEPTH):0] siloCount;
  logic                  siloFull;
  logic                  siloEmpty;

  // bus decode: access completes on the edge where ack is high
  wire        busReq   = wbReq.cyc & wbReq.stb;
  wire        busDone  = busReq & wbAck;
  wire        busWr    = busDone & wbReq.we;
  wire        busRd    = busDone & ~wbReq.we;
  wire [15:0] wdat     = wbReq.dat[15:0];
  wire [15:0] byteMask = {{8{wbReq.sel[1]}}, {8{wbReq.sel[0]}}};
  wire        hitSys   = (wbReq.adr == OFS_SYSCTL);
  wire        hitLine  = (wbReq.adr == OFS_LINECTL);
  wire        hitSel   = (wbReq.adr == OFS_SELECT);
  wire        hitSilo  = (wbReq.adr == OFS_SILO);
  wire        hitRxc   = (wbReq.adr == OFS_RXCHAR);
  wire        hitLst   = (wbReq.adr == OFS_LSTATE);
  wire        sysWr    = busWr & hitSys;
  wire        selWr    = busWr & hitSel;
  wire        siloRd   = busRd & hitSilo;
  wire        strobe   = busWr & hitLine & wbReq.sel[1] & wdat[LC_STROBE];
  wire        resyncWr = busWr & hitLst & wbReq.sel[0] & wdat[LS_RESYNC];
  wire        svcWr    = sysWr & wbReq.sel[1] & wdat[SC_SVC];
  wire        mclrWr   = sysWr & wbReq.sel[1] & wdat[SC_MCLR];
  wire        mclrNow  = sysCtl[SC_MCLR];
  wire [3:0]  curLine  = lineSelect[3:0];
  wire [1:0]  curGroup = lineSelect[3:2];
  wire        siloPush = statusPush & (~siloFull | siloRd);

  // maintenance write enable opens the two request flags to software
  wire [15:0] sysWrMask = byteMask & (SC_WR_MASK | (sysCtl[SC_MWE] ? SC_MAINT_WR : 16'h0000));

  // read-back views; write-only line control bits read as zero
  wire [15:0] lineRead  = {10'h000, secAddrHi, 4'h0};
  wire [15:0] lstRead   = {15'h0000, rxActive[curLine]};
  wire [15:0] readMux   = hitSys  ? sysCtl :
                          hitLine ? lineRead :
                          hitSel  ? lineSelect :
                          hitSilo ? siloHead :
                          hitRxc  ? rxCharReg :
                          hitLst  ? lstRead : 16'h0000;

  always_comb begin
    next_sysCtl = sysCtl;
    if (sysWr) begin
      next_sysCtl = (sysCtl & ~sysWrMask) | (wdat & sysWrMask);
    end
    next_sysCtl[SC_MCLR] = mclrWr;
    if (svcWr) begin
      next_sysCtl[SC_SVC]   = 1'b1;
      next_sysCtl[SC_RXREQ] = 1'b0;
    end
    if (mclrNow) begin
      next_sysCtl = next_sysCtl & SC_MCLR_KEEP;
    end
    if (siloRd) begin
      next_sysCtl[SC_STAT] = 1'b0;
    end
    // hardware sets come last so they win over any clear
    if (rxEvtValid) begin
      next_sysCtl[SC_RXREQ] = 1'b1;
      next_sysCtl[SC_SVC]   = 1'b0;
    end
    if (siloPush) begin
      next_sysCtl[SC_STAT] = 1'b1;
    end
    if (siloFull) begin
      next_sysCtl[SC_OVF] = 1'b1;
    end
  end

  always_comb begin
    next_rxEnable = lineRxEnable;
    next_rxActive = rxActive;
    if (mclrNow) begin
      next_rxEnable = '0;
    end
    if (strobe) begin
      next_rxEnable[curLine] = wdat[LC_RXEN];
    end
    if (resyncWr) begin
      next_rxActive[curLine] = 1'b0;
    end
    if (syncFound) begin
      next_rxActive[syncLine] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sysCtl <= SC_RESET;
    end else begin
      sysCtl <= next_sysCtl;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lineRxEnable <= '0;
      rxActive     <= '0;
      lineHunt     <= '0;
    end else begin
      lineRxEnable <= next_rxEnable;
      rxActive     <= next_rxActive;
      lineHunt     <= next_rxEnable & ~next_rxActive;
    end
  end

  // group storage: one entry per four lines
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      groupCtl <= {4{GRP_RESET}};
    end else if (strobe) begin
      groupCtl[curGroup] <= '{maint14: wdat[LC_M14], maint12: wdat[LC_M12],
                              maint11: wdat[LC_M11], syncB: wdat[LC_SYNC],
                              maint09: wdat[LC_M09]};
    end else if (mclrNow) begin
      groupCtl <= {4{GRP_RESET}};
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lineSelect <= SEL_RESET;
    end else if (selWr) begin
      lineSelect <= (lineSelect & ~byteMask) | (wdat & byteMask);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rxCharReg <= RXC_RESET;
    end else if (rxEvtValid) begin
      rxCharReg <= rxEvt;
    end else if (mclrNow) begin
      rxCharReg <= RXC_RESET;
    end
  end

  // registered ack, one wait state; unmapped offsets answer zero
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wbAck    <= 1'b0;
      wbDatOut <= 32'h0000_0000;
    end else begin
      wbAck    <= busReq & ~wbAck;
      wbDatOut <= (busReq & ~wbAck & ~wbReq.we) ? {16'h0000, readMux} : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      serviceComplete <= 1'b0;
      rxIrqReq        <= 1'b0;
      statIrqReq      <= 1'b0;
    end else begin
      serviceComplete <= svcWr;
      rxIrqReq        <= next_sysCtl[SC_RXIE] & next_sysCtl[SC_RXREQ];
      statIrqReq      <= (next_sysCtl[SC_OVFIE] & next_sysCtl[SC_OVF]) |
                         (next_sysCtl[SC_STIE] & next_sysCtl[SC_STAT]);
    end
  end

  assign engineGo    = sysCtl[SC_GO];
  assign extAddr     = sysCtl[SC_EXT+1:SC_EXT];
  assign masterClear = sysCtl[SC_MCLR];

  mxslc_status_silo #(
    .WIDTH (16),
    .DEPTH (SILO_DEPTH)
  ) u_silo (
    .clk      (clk),
    .reset_n  (reset_n),
    .flush    (mclrNow),
    .push     (statusPush),
    .pushData (statusEntry),
    .pop      (siloRd),
    .head     (siloHead),
    .count    (siloCount),
    .full     (siloFull),
    .empty    (siloEmpty)
  );

  property p_strobe_rxen;
    @(posedge clk) disable iff (!reset_n)
      strobe |=> lineRxEnable[$past(curLine)] == $past(wdat[LC_RXEN]);
  endproperty
  a_strobe_rxen: assert property (p_strobe_rxen) else $error("rx enable not strobed");

  property p_strobe_group;
    @(posedge clk) disable iff (!reset_n)
      strobe |=> groupCtl[$past(curGroup)].syncB == $past(wdat[LC_SYNC])
                 && groupCtl[$past(curGroup)].maint09 == $past(wdat[LC_M09]);
  endproperty
  a_strobe_group: assert property (p_strobe_group) else $error("group store wrong");

  property p_line_read;
    @(posedge clk) disable iff (!reset_n)
      (busReq && !wbAck && !wbReq.we && hitLine)
        |=> wbAck && wbDatOut[5:4] == $past(secAddrHi) && !wbDatOut[15];
  endproperty
  a_line_read: assert property (p_line_read) else $error("line control read wrong");

  property p_ext_read;
    @(posedge clk) disable iff (!reset_n)
      (busReq && !wbAck && !wbReq.we && hitSys) |=> wbDatOut[5:4] == extAddr;
  endproperty
  a_ext_read: assert property (p_ext_read) else $error("ext address readback wrong");

  property p_rx_irq;
    @(posedge clk) disable iff (!reset_n)
      rxIrqReq == (sysCtl[SC_RXIE] && sysCtl[SC_RXREQ]);
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("rx irq not gated");

  property p_rx_evt;
    @(posedge clk) disable iff (!reset_n)
      rxEvtValid |=> sysCtl[SC_RXREQ] && rxCharReg == $past(rxEvt);
  endproperty
  a_rx_evt: assert property (p_rx_evt) else $error("rx event not latched");

  property p_service;
    @(posedge clk) disable iff (!reset_n)
      (svcWr && !rxEvtValid) |=> !sysCtl[SC_RXREQ] && serviceComplete ##1 !serviceComplete;
  endproperty
  a_service: assert property (p_service) else $error("service complete failed");

  property p_overflow;
    @(posedge clk) disable iff (!reset_n)
      (siloFull && !mclrNow) |=> sysCtl[SC_OVF];
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow not flagged");

  property p_mclr;
    @(posedge clk) disable iff (!reset_n)
      mclrWr |=> masterClear ##1 (!masterClear && !engineGo && siloCount == '0 && lineRxEnable == '0);
  endproperty
  a_mclr: assert property (p_mclr) else $error("master clear incomplete");

  property p_stat_push;
    @(posedge clk) disable iff (!reset_n)
      (statusPush && !siloFull && !mclrNow) |=> sysCtl[SC_STAT] && !siloEmpty;
  endproperty
  a_stat_push: assert property (p_stat_push) else $error("status flag not set");

  property p_strobe_zero;
    @(posedge clk) disable iff (!reset_n)
      wbAck |-> wbDatOut[31:16] == 16'h0000 && !(hitLine && wbDatOut[LC_STROBE]);
  endproperty
  a_strobe_zero: assert property (p_strobe_zero) else $error("upper data not zero");

  property p_reset_clear;
    @(posedge clk)
      !reset_n |=> groupCtl == '0 && !engineGo && extAddr == 2'b00;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset left state");

  property p_maint_rx;
    @(posedge clk) disable iff (!reset_n)
      (sysWr && !sysCtl[SC_MWE] && wbReq.sel[0] && wdat[SC_RXREQ] && !sysCtl[SC_RXREQ]
       && !rxEvtValid) |=> !sysCtl[SC_RXREQ];
  endproperty
  a_maint_rx: assert property (p_maint_rx) else $error("rx request written while locked");

  property p_maint_stat;
    @(posedge clk) disable iff (!reset_n)
      (sysWr && sysCtl[SC_MWE] && wbReq.sel[1] && !mclrNow)
        |=> sysCtl[SC_STAT] == ($past(wdat[SC_STAT]) || $past(siloPush));
  endproperty
  a_maint_stat: assert property (p_maint_stat) else $error("status flag write wrong");

  property p_silo_pop;
    @(posedge clk) disable iff (!reset_n)
      (siloRd && !siloEmpty && !statusPush && !mclrNow)
        |=> siloCount == $past(siloCount) - 1'b1;
  endproperty
  a_silo_pop: assert property (p_silo_pop) else $error("silo read did not pop");

endmodule
`default_nettype wire

// *** tb/mxslc_host_model.sv ***
// mxslc_host_model: host software side, a classic wishbone master with register tasks
// assumes a slave on the same clock that answers every request with a one-cycle ack
`timescale 1ns/100ps
`default_nettype none
module mxslc_host_model (
  // clock
  input  wire logic                 clk,
  // wishbone master
  output var mxslc_pkg::mxslc_wb_req_t wbReq,
  input  wire logic                 wbAck,
  input  wire logic [31:0]          wbDatOut
);
  import mxslc_pkg::*;

  initial wbReq = '0;

  // request held until ack is sampled; no fixed latency assumed
  task automatic busCycle(input logic wr, input logic [7:0] adr, input logic [15:0] wdat,
                          output logic [15:0] rdat);
    @(posedge clk);
    wbReq <= '{1'b1, 1'b1, wr, 4'h3, adr, {16'h0000, wdat}};
    do @(posedge clk); while (wbAck !== 1'b1);
    rdat = wbDatOut[15:0];
    wbReq <= '0;
    @(posedge clk);
  endtask

  task automatic wbWrite(input logic [7:0] adr, input logic [15:0] dat);
    logic [15:0] unused;
    busCycle(1'b1, adr, dat, unused);
  endtask

  task automatic wbRead(input logic [7:0] adr, output logic [15:0] dat);
    busCycle(1'b0, adr, 16'h0000, dat);
  endtask

  // whole bits 14:9 field sent with every strobe, line chosen first
  task automatic strobeLine(input logic [3:0] line, input logic [5:0] field);
    wbWrite(OFS_SELECT, {12'h000, line});
    wbWrite(OFS_LINECTL, {1'b1, field, 9'h000});
  endtask
endmodule
`default_nettype wire

// *** tb/mxslc_tb_top.sv ***
// mxslc_tb_top: directed register tests for the system and line control block
// assumes the host model as bus master and the bench driving engine events
`timescale 1ns/100ps
`default_nettype none
module mxslc_tb_top;
  import mxslc_pkg::*;

  localparam int TIMEOUT_CYCLES = 5000;

  logic                  clk;
  logic                  reset_n;
  mxslc_wb_req_t         wbReq;
  logic                  wbAck;
  logic [31:0]           wbDatOut;
  logic                  rxEvtValid;
  mxslc_rx_evt_t         rxEvt;
  logic                  statusPush;
  logic [15:0]           statusEntry;
  logic                  syncFound;
  logic [3:0]            syncLine;
  logic [1:0]            secAddrHi;
  logic                  engineGo;
  logic [1:0]            extAddr;
  logic                  serviceComplete;
  logic                  masterClear;
  logic [15:0]           lineSelect;
  logic [15:0]           lineRxEnable;
  logic [15:0]           lineHunt;
  mxslc_grp_ctl_t [3:0]  groupCtl;
  logic                  rxIrqReq;
  logic                  statIrqReq;
  logic [15:0]           rdData;
  logic [15:0]           expEn;
  logic                  svcSeen;
  logic                  mcSeen;
  logic [5:0]            fTab [4] = '{6'h11, 6'h32, 6'h1C, 6'h33};
  int                    errors;
  int                    compares;
  int                    cycleCount;
  int                    entryCount;

  mxslc_top mxslc_top_inst (
    .clk(clk), .reset_n(reset_n), .wbReq(wbReq), .wbAck(wbAck), .wbDatOut(wbDatOut),
    .rxEvtValid(rxEvtValid), .rxEvt(rxEvt), .statusPush(statusPush),
    .statusEntry(statusEntry), .syncFound(syncFound), .syncLine(syncLine),
    .secAddrHi(secAddrHi), .engineGo(engineGo), .extAddr(extAddr),
    .serviceComplete(serviceComplete), .masterClear(masterClear),
    .lineSelect(lineSelect), .lineRxEnable(lineRxEnable), .lineHunt(lineHunt),
    .groupCtl(groupCtl), .rxIrqReq(rxIrqReq), .statIrqReq(statIrqReq)
  );

  mxslc_host_model mxslc_host_model_inst (
    .clk(clk), .wbReq(wbReq), .wbAck(wbAck), .wbDatOut(wbDatOut)
  );

  always #20 clk = ~clk;

  // pulses are one cycle wide, so latch them for later checks
  always @(posedge clk) begin
    if (serviceComplete === 1'b1) svcSeen <= 1'b1;
    if (masterClear === 1'b1) mcSeen <= 1'b1;
    cycleCount <= cycleCount + 1;
    if (cycleCount == TIMEOUT_CYCLES) begin
      errors++;
      $display("timeout after %0d cycles", cycleCount);
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("counts: %0d compares, %0d errors", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check16(input string what, input logic [15:0] expv, input logic [15:0] got);
    compares++;
    if (got !== expv) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, expv, got);
    end
  endtask

  task automatic check1(input string what, input logic expv, input logic got);
    compares++;
    if (got !== expv) begin
      errors++;
      $display("mismatch %s expected %b seen %b", what, expv, got);
    end
  endtask

  task automatic pulseRx(input logic [15:0] evt);
    @(posedge clk);
    rxEvtValid <= 1'b1;
    rxEvt      <= evt;
    @(posedge clk);
    rxEvtValid <= 1'b0;
  endtask

  task automatic pushStatus(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      statusPush  <= 1'b1;
      statusEntry <= 16'h0100 + 16'(entryCount);
      entryCount++;
    end
    @(posedge clk);
    statusPush <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  initial begin
    clk = 1'b0; reset_n = 1'b0; rxEvtValid = 1'b0; rxEvt = '0; statusPush = 1'b0;
    statusEntry = '0; syncFound = 1'b0; syncLine = '0; secAddrHi = 2'b10; expEn = '0;
    svcSeen = 1'b0; mcSeen = 1'b0; errors = 0; compares = 0; cycleCount = 0; entryCount = 0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    mxslc_host_model_inst.wbRead(OFS_SYSCTL, rdData);
    check16("sysctl reset", SC_RESET, rdData);
    check1("group store clear", 1'b1, groupCtl == '0);
    mxslc_host_model_inst.wbWrite(OFS_SYSCTL, 16'h0031);
    mxslc_host_model_inst.wbRead(OFS_SYSCTL, rdData);
    check16("sysctl ext go", 16'h0031, rdData);
    check1("engineGo", 1'b1, engineGo);
    check16("extAddr", 16'h0003, {14'h0000, extAddr});
    mxslc_host_model_inst.wbWrite(8'h20, 16'hFFFF);
    mxslc_host_model_inst.wbRead(8'h20, rdData);
    check16("unmapped", 16'h0000, rdData);
    $display("test system control done");

    // one line per group, each group gets its own bit pattern
    for (int i = 0; i < 4; i++) begin
      mxslc_host_model_inst.strobeLine(4'(i * 5), fTab[i]);
      expEn[i * 5] = 1'b1;
    end
    repeat (2) @(posedge clk);
    check16("lineRxEnable", expEn, lineRxEnable);
    check16("lineHunt", expEn, lineHunt);
    for (int i = 0; i < 4; i++) begin
      check16("groupCtl", {11'h000, fTab[i][5], fTab[i][3:0]}, {11'h000, groupCtl[i]});
    end
    mxslc_host_model_inst.wbRead(OFS_LINECTL, rdData);
    check16("linectl read", 16'h0020, rdData);
    secAddrHi <= 2'b01;
    mxslc_host_model_inst.wbRead(OFS_LINECTL, rdData);
    check16("linectl ext read", 16'h0010, rdData);
    @(posedge clk);
    syncFound <= 1'b1;
    syncLine  <= 4'h5;
    @(posedge clk);
    syncFound <= 1'b0;
    repeat (2) @(posedge clk);
    check16("lineHunt after sync", expEn & 16'hFFDF, lineHunt);
    mxslc_host_model_inst.wbWrite(OFS_SELECT, 16'h0005);
    check16("lineSelect", 16'h0005, lineSelect);
    mxslc_host_model_inst.wbRead(OFS_LSTATE, rdData);
    check16("line active", 16'h0001, rdData);
    mxslc_host_model_inst.strobeLine(4'h5, 6'h00);
    mxslc_host_model_inst.wbWrite(OFS_LSTATE, 16'h0002);
    mxslc_host_model_inst.wbRead(OFS_LSTATE, rdData);
    check16("line stopped", 16'h0000, rdData);
    check1("rx enable off", 1'b0, lineRxEnable[5]);
    $display("test line control done");

    mxslc_host_model_inst.wbWrite(OFS_SYSCTL, 16'h0040);
    pulseRx(16'h355A);
    repeat (2) @(posedge clk);
    check1("rxIrqReq set", 1'b1, rxIrqReq);
    mxslc_host_model_inst.wbRead(OFS_SYSCTL, rdData);
    check16("sysctl rx req", 16'h00C0, rdData);
    mxslc_host_model_inst.wbRead(OFS_RXCHAR, rdData);
    check16("rx char", 16'h355A, rdData);
    mxslc_host_model_inst.wbWrite(OFS_SYSCTL, 16'h0140);
    mxslc_host_model_inst.wbRead(OFS_SYSCTL, rdData);
    check16("sysctl serviced", 16'h0140, rdData);
    check1("rxIrqReq clear", 1'b0, rxIrqReq);
    check1("serviceComplete", 1'b1, svcSeen);
    mxslc_host_model_inst.wbWrite(OFS_SYSCTL, 16'h0080);
    mxslc_host_model_inst.wbRead(OFS_SYSCTL, rdData);
    check16("rx req locked", 16'h0100, rdData);
    mxslc_host_model_inst.wbWrite(OFS_SYSCTL, 16'h0200);
    mxslc_host_model_inst.wbWrite(OFS_SYSCTL, 16'h0280);
    mxslc_host_model_inst.wbRead(OFS_SYSCTL, rdData);
    check16("rx req maint", 16'h0380, rdData);
    mxslc_host_model_inst.wbWrite(OFS_SYSCTL, 16'h8200);
    mxslc_host_model_inst.wbRead(OFS_SYSCTL, rdData);
    check16("status maint", 16'h8300, rdData);
    mxslc_host_model_inst.wbWrite(OFS_SYSCTL, 16'h0000);
    pulseRx(16'h4321);
    repeat (2) @(posedge clk);
    check1("rxIrqReq masked", 1'b0, rxIrqReq);
    mxslc_host_model_inst.wbRead(OFS_SYSCTL, rdData);
    check16("rx event unmasked", 16'h0080, rdData);
    $display("test receive interrupt done");

    mxslc_host_model_inst.wbWrite(OFS_SYSCTL, 16'h1100);
    pushStatus(63);
    check1("statIrqReq 63", 1'b0, statIrqReq);
    pushStatus(1);
    check1("statIrqReq 64", 1'b1, statIrqReq);
    mxslc_host_model_inst.wbRead(OFS_SYSCTL, rdData);
    check16("sysctl silo full", 16'h9500, rdData);
    for (int i = 0; i < 64; i++) begin
      mxslc_host_model_inst.wbRead(OFS_SILO, rdData);
      check16("silo entry", 16'h0100 + 16'(i), rdData);
      if (i == 0) begin
        mxslc_host_model_inst.wbRead(OFS_SYSCTL, rdData);
        check1("status flag read", 1'b0, rdData[SC_STAT]);
      end
    end
    mxslc_host_model_inst.wbWrite(OFS_SYSCTL, 16'h2000);
    pushStatus(1);
    check1("statIrqReq enabled", 1'b1, statIrqReq);
    mxslc_host_model_inst.wbRead(OFS_SILO, rdData);
    check16("silo single", 16'h0140, rdData);
    repeat (2) @(posedge clk);
    check1("statIrqReq drained", 1'b0, statIrqReq);
    $display("test status silo done");

    mxslc_host_model_inst.strobeLine(4'h3, 6'h3F);
    mxslc_host_model_inst.wbWrite(OFS_SYSCTL, 16'h3E71);
    repeat (3) @(posedge clk);
    mxslc_host_model_inst.wbRead(OFS_SYSCTL, rdData);
    check16("sysctl cleared", 16'h0130, rdData);
    check1("go cleared", 1'b0, engineGo);
    check1("masterClear", 1'b1, mcSeen);
    check16("rx enables cleared", 16'h0000, lineRxEnable);
    check1("groups cleared", 1'b1, groupCtl == '0);
    mxslc_host_model_inst.wbRead(OFS_RXCHAR, rdData);
    check16("rx char cleared", 16'h0000, rdData);
    $display("test master clear done");
    end_of_test();
  end
endmodule
`default_nettype wire
